/* gpio_seg_mux_ports.sv */
// Top of the eight-pin and three-pin GPIO/segment port groups with APB registers
//
// Behaviour
// - Eight-pin group, GPIO or LCD segment per pin
// - Three-pin group, GPIO or LCD segment per pin
// - GPIO use: segment off, enables govern pin
// - Gate bit three of control gates GPIO drive and input of both groups, not segment use
// - Output enable active low
// - Input enable active high
// - Eight-pin registers at indices 28d5 to 28d8
// - Three-pin registers 28d9 to 28dc, bits 2:0
// - Enabled input data follows pin level continuously
//
// Decided for this implementation: the APB register port.
module gpio_seg_mux_ports
  import gsmp_pkg::*;
#(
  parameter int G7_W = G7_PINS,
  parameter int G8_W = G8_PINS
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  input  wire logic [3:0]        pstrb,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Eight-pin group pins
  input  wire logic [G7_W-1:0]   g7_pin_in,
  output logic      [G7_W-1:0]   g7_pin_out,
  output logic      [G7_W-1:0]   g7_pin_oe,
  // Eight-pin group segment outputs of the LCD driver
  input  wire logic [G7_W-1:0]   g7_seg_data,
  input  wire logic [G7_W-1:0]   g7_seg_en,
  // Three-pin group pins
  input  wire logic [G8_W-1:0]   g8_pin_in,
  output logic      [G8_W-1:0]   g8_pin_out,
  output logic      [G8_W-1:0]   g8_pin_oe,
  // Three-pin group segment outputs of the LCD driver
  input  wire logic [G8_W-1:0]   g8_seg_data,
  input  wire logic [G8_W-1:0]   g8_seg_en
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [G7_W-1:0]   oe7;
    logic [G7_W-1:0]   ie7;
    logic [G7_W-1:0]   od7;
    logic [G8_W-1:0]   oe8;
    logic [G8_W-1:0]   ie8;
    logic [G8_W-1:0]   od8;
    logic              gate;
    logic [DATA_W-1:0] rdata;
    logic              slverr;
  } gsmp_regs_s;

  gsmp_regs_s cur_reg;
  gsmp_regs_s cur_next;

  logic       setup_phase;
  logic       access_phase;
  logic       wr_take;
  logic       lane0;
  logic       mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Group carriers

  gsmp_group_if #(.W(G7_W)) g7_if ();
  gsmp_group_if #(.W(G8_W)) g8_if ();

  ////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  // Any register of this block at the given byte address
  function automatic logic addr_mapped(input logic [ADDR_W-1:0] addr);
    logic m;
    m = 1'b0;
    if (gsmp_hit(addr, IDX_G7_OE)) begin
      m = 1'b1;
    end else if (gsmp_hit(addr, IDX_G7_IE)) begin
      m = 1'b1;
    end else if (gsmp_hit(addr, IDX_G7_OD)) begin
      m = 1'b1;
    end else if (gsmp_hit(addr, IDX_G7_ID)) begin
      m = 1'b1;
    end else if (gsmp_hit(addr, IDX_G8_OE)) begin
      m = 1'b1;
    end else if (gsmp_hit(addr, IDX_G8_IE)) begin
      m = 1'b1;
    end else if (gsmp_hit(addr, IDX_G8_OD)) begin
      m = 1'b1;
    end else if (gsmp_hit(addr, IDX_G8_ID)) begin
      m = 1'b1;
    end else if (gsmp_hit(addr, IDX_PORT_CTRL)) begin
      m = 1'b1;
    end
    return m;
  endfunction : addr_mapped

  // Control register image: only the gate bit is implemented
  function automatic logic [DATA_W-1:0] ctrl_image(input logic gate);
    logic [DATA_W-1:0] v;
    v           = RDATA_RST;
    v[GATE_BIT] = gate;
    return v;
  endfunction : ctrl_image

  ////////////////////////////////////////////////////////////////////////////
  // APB phase qualifiers
  //
  // Zero-wait slave: read data is captured in the setup cycle so that it
  // comes from a flip-flop during the access cycle.

  assign setup_phase  = psel & ~penable;
  assign access_phase = psel & penable;
  assign lane0        = pstrb[0];
  assign mapped       = addr_mapped(paddr);
  assign wr_take      = access_phase & pwrite & lane0 & mapped;

  ////////////////////////////////////////////////////////////////////////////
  // Register select decode
  //
  // One decode feeds the write chain, the read chain and the id strobes.
  // Unaligned addresses never hit, so every select stays low for them.

  typedef struct packed {
    logic g7_oe;
    logic g7_ie;
    logic g7_od;
    logic g7_id;
    logic g8_oe;
    logic g8_ie;
    logic g8_od;
    logic g8_id;
    logic ctrl;
  } gsmp_sel_s;

  gsmp_sel_s  sel;
  logic       id7_wr;
  logic       id8_wr;

  always_comb begin
    sel = '0;
    if (gsmp_hit(paddr, IDX_G7_OE)) begin
      sel.g7_oe = 1'b1;
    end else if (gsmp_hit(paddr, IDX_G7_IE)) begin
      sel.g7_ie = 1'b1;
    end else if (gsmp_hit(paddr, IDX_G7_OD)) begin
      sel.g7_od = 1'b1;
    end else if (gsmp_hit(paddr, IDX_G7_ID)) begin
      sel.g7_id = 1'b1;
    end else if (gsmp_hit(paddr, IDX_G8_OE)) begin
      sel.g8_oe = 1'b1;
    end else if (gsmp_hit(paddr, IDX_G8_IE)) begin
      sel.g8_ie = 1'b1;
    end else if (gsmp_hit(paddr, IDX_G8_OD)) begin
      sel.g8_od = 1'b1;
    end else if (gsmp_hit(paddr, IDX_G8_ID)) begin
      sel.g8_id = 1'b1;
    end else if (gsmp_hit(paddr, IDX_PORT_CTRL)) begin
      sel.ctrl = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input data write strobes

  assign id7_wr = wr_take & sel.g7_id;
  assign id8_wr = wr_take & sel.g8_id;

  ////////////////////////////////////////////////////////////////////////////
  // Register file next state

  always_comb begin
    cur_next = cur_reg;

    // Writes land at the access edge; upper data bits are ignored
    if (wr_take) begin
      if (sel.g7_oe) begin
        cur_next.oe7 = pwdata[G7_W-1:0];
      end else if (sel.g7_ie) begin
        cur_next.ie7 = pwdata[G7_W-1:0];
      end else if (sel.g7_od) begin
        cur_next.od7 = pwdata[G7_W-1:0];
      end else if (sel.g8_oe) begin
        cur_next.oe8 = pwdata[G8_W-1:0];
      end else if (sel.g8_ie) begin
        cur_next.ie8 = pwdata[G8_W-1:0];
      end else if (sel.g8_od) begin
        cur_next.od8 = pwdata[G8_W-1:0];
      end else if (sel.ctrl) begin
        cur_next.gate = pwdata[GATE_BIT];
      end
    end

    // Read data and error captured during setup, held through access
    if (setup_phase) begin
      cur_next.rdata  = RDATA_RST;
      cur_next.slverr = ~mapped;
      if (!pwrite) begin
        if (sel.g7_oe) begin
          cur_next.rdata = DATA_W'(cur_reg.oe7);
        end else if (sel.g7_ie) begin
          cur_next.rdata = DATA_W'(cur_reg.ie7);
        end else if (sel.g7_od) begin
          cur_next.rdata = DATA_W'(cur_reg.od7);
        end else if (sel.g7_id) begin
          cur_next.rdata = DATA_W'(g7_if.id);
        end else if (sel.g8_oe) begin
          cur_next.rdata = DATA_W'(cur_reg.oe8);
        end else if (sel.g8_ie) begin
          cur_next.rdata = DATA_W'(cur_reg.ie8);
        end else if (sel.g8_od) begin
          cur_next.rdata = DATA_W'(cur_reg.od8);
        end else if (sel.g8_id) begin
          cur_next.rdata = DATA_W'(g8_if.id);
        end else if (sel.ctrl) begin
          cur_next.rdata = ctrl_image(cur_reg.gate);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file storage

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg.oe7    <= OE_RST[G7_W-1:0];
      cur_reg.ie7    <= IE_RST[G7_W-1:0];
      cur_reg.od7    <= OD_RST[G7_W-1:0];
      cur_reg.oe8    <= OE_RST[G8_W-1:0];
      cur_reg.ie8    <= IE_RST[G8_W-1:0];
      cur_reg.od8    <= OD_RST[G8_W-1:0];
      cur_reg.gate   <= GATE_RST;
      cur_reg.rdata  <= RDATA_RST;
      cur_reg.slverr <= 1'b0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB outputs

  assign prdata  = cur_reg.rdata;
  assign pready  = 1'b1;
  // Error only shown in the access cycle, low otherwise
  assign pslverr = access_phase & cur_reg.slverr;

  ////////////////////////////////////////////////////////////////////////////
  // Eight-pin group

  assign g7_if.oe_n     = cur_reg.oe7;
  assign g7_if.ie       = cur_reg.ie7;
  assign g7_if.od       = cur_reg.od7;
  assign g7_if.gate     = cur_reg.gate;
  assign g7_if.id_wdata = pwdata[G7_W-1:0];
  assign g7_if.id_wr    = id7_wr;

  // Per-pin GPIO or segment selection
  gsmp_port_group #(
    .W        (G7_W)
  ) u_g7 (
    .pclk     (pclk),
    .presetn  (presetn),
    .rif      (g7_if.group),
    .pin_in   (g7_pin_in),
    .pin_out  (g7_pin_out),
    .pin_oe   (g7_pin_oe),
    .seg_data (g7_seg_data),
    .seg_en   (g7_seg_en)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Three-pin group
  //
  // Only the low bits exist; upper bits of its registers read as zero.

  assign g8_if.oe_n     = cur_reg.oe8;
  assign g8_if.ie       = cur_reg.ie8;
  assign g8_if.od       = cur_reg.od8;
  assign g8_if.gate     = cur_reg.gate;
  assign g8_if.id_wdata = pwdata[G8_W-1:0];
  assign g8_if.id_wr    = id8_wr;

  // Per-pin GPIO or segment selection
  gsmp_port_group #(
    .W        (G8_W)
  ) u_g8 (
    .pclk     (pclk),
    .presetn  (presetn),
    .rif      (g8_if.group),
    .pin_in   (g8_pin_in),
    .pin_out  (g8_pin_out),
    .pin_oe   (g8_pin_oe),
    .seg_data (g8_seg_data),
    .seg_en   (g8_seg_en)
  );

endmodule : gpio_seg_mux_ports

/* gsmp_pkg.sv */
// Shared constants for the segment-multiplexed port groups
package gsmp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus widths
  localparam int DATA_W  = 32;
  localparam int ADDR_W  = 16;
  localparam int BYTE_W  = 8;

  ////////////////////////////////////////////////////////////////////////////
  // Pin counts per group
  localparam int G7_PINS = 8;
  localparam int G8_PINS = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_G7_OE     = 16'h28d5;
  localparam logic [ADDR_W-1:0] IDX_G7_IE     = 16'h28d6;
  localparam logic [ADDR_W-1:0] IDX_G7_OD     = 16'h28d7;
  localparam logic [ADDR_W-1:0] IDX_G7_ID     = 16'h28d8;
  localparam logic [ADDR_W-1:0] IDX_G8_OE     = 16'h28d9;
  localparam logic [ADDR_W-1:0] IDX_G8_IE     = 16'h28da;
  localparam logic [ADDR_W-1:0] IDX_G8_OD     = 16'h28db;
  localparam logic [ADDR_W-1:0] IDX_G8_ID     = 16'h28dc;
  localparam logic [ADDR_W-1:0] IDX_PORT_CTRL = 16'h2d00;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions and reset values
  localparam int              GATE_BIT  = 3;
  localparam logic [1:0]      WORD_LANE = 2'h0;
  localparam logic [BYTE_W-1:0] OE_RST  = 8'hff;
  localparam logic [BYTE_W-1:0] IE_RST  = 8'h00;
  localparam logic [BYTE_W-1:0] OD_RST  = 8'hff;
  localparam logic [BYTE_W-1:0] ID_RST  = 8'h00;
  localparam logic              GATE_RST = 1'b0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Byte address of a register index
  function automatic logic [ADDR_W-1:0] gsmp_byte_addr(input logic [ADDR_W-1:0] idx);
    return {idx[ADDR_W-3:0], WORD_LANE};
  endfunction : gsmp_byte_addr

  // Address match against a register index
  function automatic logic gsmp_hit(input logic [ADDR_W-1:0] addr,
                                    input logic [ADDR_W-1:0] idx);
    return addr == gsmp_byte_addr(idx);
  endfunction : gsmp_hit

endpackage : gsmp_pkg

/* gsmp_group_if.sv */
// Register-side carrier between the register file and one port group
interface gsmp_group_if #(
  parameter int W = 8
);
  logic [W-1:0] oe_n;
  logic [W-1:0] ie;
  logic [W-1:0] od;
  logic [W-1:0] id;
  logic [W-1:0] id_wdata;
  logic         id_wr;
  logic         gate;

  modport regs  (output oe_n, output ie, output od, output id_wdata, output id_wr,
                 output gate, input id);
  modport group (input oe_n, input ie, input od, input id_wdata, input id_wr,
                 input gate, output id);
endinterface : gsmp_group_if

/* gsmp_port_group.sv */
// One port group: pin muxing between GPIO and LCD segment, input data capture
module gsmp_port_group
  import gsmp_pkg::*;
#(
  parameter int W = G7_PINS
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Register side
  gsmp_group_if.group       rif,
  // Pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out,
  output logic      [W-1:0] pin_oe,
  // LCD segment driver
  input  wire logic [W-1:0] seg_data,
  input  wire logic [W-1:0] seg_en
);

  typedef struct packed {
    logic [W-1:0] id;
  } gsmp_grp_s;

  gsmp_grp_s    cur_reg;
  gsmp_grp_s    cur_next;
  logic [W-1:0] sample;
  logic [W-1:0] gpio_drive;

  ////////////////////////////////////////////////////////////////////////////
  // Pin drive and input capture
  always_comb begin
    sample     = rif.ie & {W{~rif.gate}};
    gpio_drive = ~rif.oe_n & {W{~rif.gate}};
    // Segment use takes the pin; GPIO enables govern it otherwise
    pin_oe     = seg_en | (~seg_en & gpio_drive);
    pin_out    = (seg_en & seg_data) | (~seg_en & rif.od);
    cur_next   = cur_reg;
    if (rif.id_wr) begin
      cur_next.id = rif.id_wdata;
    end
    // Pin sampling wins over a software write in the same cycle
    cur_next.id = (sample & pin_in) | (~sample & cur_next.id);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg.id <= ID_RST[W-1:0];
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign rif.id = cur_reg.id;

endmodule : gsmp_port_group

/* gsmp_monitor.sv */
// Concurrent checks on the port-group top level
module gsmp_monitor
  import gsmp_pkg::*;
#(
  parameter int G7_W = G7_PINS,
  parameter int G8_W = G8_PINS
) (
  // Clock and reset
  input wire logic              pclk,
  input wire logic              presetn,
  // APB
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [3:0]        pstrb,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  // Eight-pin group
  input wire logic [G7_W-1:0]   g7_pin_in,
  input wire logic [G7_W-1:0]   g7_pin_out,
  input wire logic [G7_W-1:0]   g7_pin_oe,
  input wire logic [G7_W-1:0]   g7_seg_data,
  input wire logic [G7_W-1:0]   g7_seg_en,
  // Three-pin group
  input wire logic [G8_W-1:0]   g8_pin_in,
  input wire logic [G8_W-1:0]   g8_pin_out,
  input wire logic [G8_W-1:0]   g8_pin_oe,
  input wire logic [G8_W-1:0]   g8_seg_data,
  input wire logic [G8_W-1:0]   g8_seg_en
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////
  logic acc;
  logic g8_hit;
  logic mapped;
  assign acc    = psel && penable;
  assign g8_hit = paddr inside {16'ha364, 16'ha368, 16'ha36c, 16'ha370};
  assign mapped = g8_hit || paddr inside {16'ha354, 16'ha358, 16'ha35c, 16'ha360, 16'hb400};
  // No write and no segment change: nothing may move the pins
  sequence quiet_s;
    !(acc && pwrite) ##1 $stable({g7_seg_en, g7_seg_data, g8_seg_en, g8_seg_data});
  endsequence
  sequence read_s;
    psel && !penable && !pwrite ##1 acc;
  endsequence
  ////////////////////////////////////////
  a_seg_own_g7: assert property ((g7_pin_oe & g7_seg_en) == g7_seg_en
    && ((g7_pin_out ^ g7_seg_data) & g7_seg_en) == '0) else $error("g7 segment lost pin");
  a_seg_own_g8: assert property ((g8_pin_oe & g8_seg_en) == g8_seg_en
    && ((g8_pin_out ^ g8_seg_data) & g8_seg_en) == '0) else $error("g8 segment lost pin");
  a_hold_g7: assert property (quiet_s |-> $stable({g7_pin_out, g7_pin_oe}))
    else $error("g7 pins moved without cause");
  a_hold_g8: assert property (quiet_s |-> $stable({g8_pin_out, g8_pin_oe}))
    else $error("g8 pins moved without cause");
  a_err_map: assert property (acc |-> pslverr == !mapped)
    else $error("error response does not match address map");
  a_err_rdata: assert property (read_s ##0 pslverr |-> prdata == '0)
    else $error("refused read returned data");
  a_rdata_hold: assert property (!(psel && !penable) |=> $stable(prdata))
    else $error("read data changed outside setup");
  a_g7_width: assert property (read_s ##0 (mapped && !g8_hit) |-> prdata[31:8] == '0)
    else $error("eight-pin read has upper bits");
  a_g8_width: assert property (read_s ##0 g8_hit |-> prdata[31:3] == '0)
    else $error("three-pin read has upper bits");
endmodule : gsmp_monitor

bind gpio_seg_mux_ports gsmp_monitor #(.G7_W(G7_W), .G8_W(G8_W)) mon (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
  .pslverr, .g7_pin_in, .g7_pin_out, .g7_pin_oe, .g7_seg_data, .g7_seg_en, .g8_pin_in,
  .g8_pin_out, .g8_pin_oe, .g8_seg_data, .g8_seg_en);

/* gsmp_board.sv */
// Board model of the port pins: external drivers and floating nets
module gsmp_board #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         clk,
  // Device pins
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  output logic      [W-1:0] pin_in,
  // External drive set by the bench
  input  wire logic [W-1:0] ext_val,
  input  wire logic [W-1:0] ext_en
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [W-1:0] last_reg = '0;
  ////////////////////////////////////////
  // Undriven net flips each cycle so a stale level never passes for a read
  always_ff @(posedge clk) begin
    last_reg <= pin_in;
  end
  always_comb begin
    for (int i = 0; i < W; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_en[i] ? ext_val[i] : ~last_reg[i]);
    end
  end
endmodule : gsmp_board

/* gpio_seg_mux_ports_bench.sv */
// Self-checking bench for the segment-multiplexed port groups
module gpio_seg_mux_ports_bench;
  import gsmp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [15:0] paddr = 16'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [3:0]  pstrb = 4'hf;
  logic        pready, pslverr;
  logic [7:0]  g7_pin_in, g7_pin_out, g7_pin_oe, g7_seg_data = 8'h0, g7_seg_en = 8'h0;
  logic [7:0]  e7_val = 8'h0, e7_en = 8'h0;
  logic [2:0]  g8_pin_in, g8_pin_out, g8_pin_oe, g8_seg_data = 3'h0, g8_seg_en = 3'h0;
  logic [2:0]  e8_val = 3'h0, e8_en = 3'h0;
  int          n_errors = 0, checks = 0;
  // Map order: g7 oe ie od id, g8 oe ie od id, control
  logic [15:0] ad [9] = '{16'ha354, 16'ha358, 16'ha35c, 16'ha360, 16'ha364, 16'ha368,
                          16'ha36c, 16'ha370, 16'hb400};
  logic [31:0] rv [9] = '{32'hff, 32'h0, 32'hff, 32'h0, 32'h7, 32'h0, 32'h7, 32'h0, 32'h0};
  always #25 pclk = ~pclk;
  ////////////////////////////////////////
  gpio_seg_mux_ports uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .g7_pin_in, .g7_pin_out, .g7_pin_oe, .g7_seg_data,
    .g7_seg_en, .g8_pin_in, .g8_pin_out, .g8_pin_oe, .g8_seg_data, .g8_seg_en);
  gsmp_board #(.W(8)) b7 (.clk(pclk), .pin_out(g7_pin_out), .pin_oe(g7_pin_oe),
    .pin_in(g7_pin_in), .ext_val(e7_val), .ext_en(e7_en));
  gsmp_board #(.W(3)) b8 (.clk(pclk), .pin_out(g8_pin_out), .pin_oe(g8_pin_oe),
    .pin_in(g8_pin_in), .ext_val(e8_val), .ext_en(e8_en));
  ////////////////////////////////////////
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("FAIL %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk
  // Request held until pready is seen high; the wait is bounded
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      n_errors++;
      give_verdict();
    end
  endtask : apb
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, {24'h0, d}, q, e);
  endtask : wr
  task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic        e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, exp, q);
    chk({nm, " err"}, 32'h0, {31'h0, e});
  endtask : rd
  ////////////////////////////////////////
  task automatic t_reset();
    for (int i = 0; i < 9; i++) rd("reset value", ad[i], rv[i]);
    @(negedge pclk);
    chk("pins idle", 32'h0, {g7_pin_oe, g8_pin_oe});
  endtask : t_reset
  task automatic t_output();
    wr(ad[2], 8'h5a);
    wr(ad[0], 8'hf0);
    wr(ad[6], 8'hfd);
    wr(ad[4], 8'hfa);
    @(negedge pclk);
    chk("g7 drive", 32'h0f5a, {g7_pin_oe, g7_pin_out});
    chk("g8 drive", 32'h55, {g8_pin_oe, 1'b0, g8_pin_out});
    rd("g8 od", ad[6], 32'h5);
    rd("g8 oe", ad[4], 32'h2);
    wr(ad[1], 8'h0f);
    rd("g7 loop", ad[3], 32'h0a);
    wr(ad[0], 8'hff);
    wr(ad[4], 8'hff);
  endtask : t_output
  task automatic t_input();
    @(posedge pclk);
    e7_en <= 8'hff;
    e7_val <= 8'hc3;
    wr(ad[1], 8'hf0);
    rd("g7 id on", ad[3], 32'hc3);
    e7_val <= 8'h3c;
    rd("g7 id follow", ad[3], 32'h33);
    wr(ad[1], 8'h00);
    e7_val <= 8'hff;
    rd("g7 id hold", ad[3], 32'h33);
    wr(ad[3], 8'h96);
    rd("g7 id write", ad[3], 32'h96);
    e8_en <= 3'h7;
    e8_val <= 3'h5;
    wr(ad[5], 8'h07);
    rd("g8 id", ad[7], 32'h5);
  endtask : t_input
  task automatic t_gate();
    wr(ad[0], 8'h00);
    wr(ad[8], 8'h08);
    e8_val <= 3'h2;
    @(negedge pclk);
    chk("gated oe", 32'h0, {g7_pin_oe, g8_pin_oe});
    rd("ctrl", ad[8], 32'h8);
    rd("gated id", ad[7], 32'h5);
    wr(ad[8], 8'h00);
    @(negedge pclk);
    chk("ungated oe", 32'hff, {24'h0, g7_pin_oe});
    rd("ungated id", ad[7], 32'h2);
    wr(ad[0], 8'hff);
  endtask : t_gate
  task automatic t_segment();
    wr(ad[5], 8'h00);
    @(posedge pclk);
    g7_seg_en <= 8'h81;
    g7_seg_data <= 8'h01;
    g8_seg_en <= 3'h2;
    g8_seg_data <= 3'h2;
    @(negedge pclk);
    chk("g7 seg", 32'h815b, {g7_pin_oe, g7_pin_out});
    chk("g8 seg", 32'h27, {g8_pin_oe, 1'b0, g8_pin_out});
    @(posedge pclk);
    g7_seg_en <= 8'h0;
    g8_seg_en <= 3'h0;
  endtask : t_segment
  task automatic t_refuse();
    logic [31:0] q;
    logic        e;
    apb(1'b0, 16'ha374, 32'h0, q, e);
    chk("unmapped read", 32'h1, {q[30:0], e});
    apb(1'b1, 16'ha355, 32'hff, q, e);
    chk("unaligned err", 32'h1, {31'h0, e});
    pstrb <= 4'h0;
    wr(ad[2], 8'h00);
    pstrb <= 4'hf;
    rd("strobe off", ad[2], 32'h5a);
  endtask : t_refuse
  ////////////////////////////////////////
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_output();
    t_input();
    t_gate();
    t_segment();
    t_refuse();
    give_verdict();
  end
endmodule : gpio_seg_mux_ports_bench
